// ===== rtl/sas_regs.vh
/*
 * Register map, field positions, reset values and timing figures of the
 * successive approximation converter sequencer.
 * Assumes a 50 MHz system clock and the 8-bit special-function-register
 * bus of the on-chip microcontroller.
 */
`ifndef SAS_REGS_VH
`define SAS_REGS_VH

`define SAS_ADDR_RESULT     8'hC2
`define SAS_ADDR_CONTROL    8'hC3

`define SAS_CTRL_REQ_BIT    0
`define SAS_CTRL_CHSEL_BIT  1
`define SAS_CTRL_AUTO_BIT   2

`define SAS_RESULT_RESET    8'h00
`define SAS_CONTROL_RESET   8'h00
`define SAS_READ_UNMAPPED   8'h00

`define SAS_CODE_WIDTH      8
`define SAS_MSB_MASK        8'h80

`define SAS_CLK_MHZ         50
`define SAS_CLK_KHZ         50000
`define SAS_SETTLE_NS       1000
`define SAS_AUTO_PERIOD_MS  30
`define SAS_CONV_LIMIT_MS   50

`endif

// ===== rtl/sas_sar_core.v
/*
 * Approximation register: trial bit mask and code, most significant first.
 * Assumes the sequencer pulses i_start once per conversion and i_decide
 * once per settled comparator decision, never both in one cycle.
 */
`timescale 1ns/1ps
`include "sas_regs.vh"

module sas_sar_core (
	input  wire       i_clk_sys,
	input  wire       i_rst_n,
	input  wire       i_start,
	input  wire       i_decide,
	input  wire       i_cmp_high,
	output wire [7:0] o_code,
	output wire       o_last
);

	localparam [7:0] MSB_MASK = `SAS_MSB_MASK;

	reg  [7:0] code_ff;
	reg  [7:0] mask_ff;
	wire [7:0] nxt_code;
	wire [7:0] nxt_mask;

	assign nxt_mask = i_start  ? `SAS_MSB_MASK :
	                  i_decide ? {1'b0, mask_ff[7:1]} : mask_ff;

	genvar g;
	generate
		for (g = 0; g < `SAS_CODE_WIDTH; g = g + 1) begin : g_bit
			wire trial;
			if (g == `SAS_CODE_WIDTH - 1) begin : g_top
				assign trial = 1'b0;
			end else begin : g_low
				assign trial = mask_ff[g + 1];
			end
			// keep the bit when input is at or above the trial level,
			// then trial-set the next lower bit
			assign nxt_code[g] = i_start ? MSB_MASK[g] :
			                     (i_decide & mask_ff[g]) ? i_cmp_high :
			                     (i_decide & trial) ? 1'b1 : code_ff[g];
		end
	endgenerate

	always @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			code_ff <= 8'h00;
			mask_ff <= 8'h00;
		end else begin
			code_ff <= nxt_code;
			mask_ff <= nxt_mask;
		end
	end

	assign o_code = code_ff;
	assign o_last = mask_ff[0];

endmodule

// ===== rtl/sas_sequencer.v
/*
 * Converter sequencer: control and result registers on the SFR bus,
 * conversion state machine, automatic-conversion interval timer.
 * Assumes an external comparator that reports the selected analog input
 * against the code driven on o_dac_code, and a system-on level input.
 */
`timescale 1ns/1ps
`include "sas_regs.vh"

// Contract
// - One 8-bit converter serves two analog inputs through a mux.
// - Control bit 1 clear selects input zero, set selects input one.
// - Control bit 0 starts a conversion; hardware clears it when done.
// - Each decision updates the code; after eight it goes to the result.
// - The time from request to new result stays below 50 ms.
// - With control bit 2 set a conversion runs every 30 ms, request or not.
// - Control bits 7 to 3 are reserved and do nothing.
// - The result holds the 8-bit code over 0 to 2000 mV in 8 mV steps.
// - The result register is read-only and resets to zero.
// - The converter is active only in the system-on state.
module sas_sequencer #(
	parameter integer P_AUTO_CYCLES = `SAS_AUTO_PERIOD_MS * `SAS_CLK_KHZ
) (
	input  wire       i_clk_sys,
	input  wire       i_rst_n,
	input  wire [7:0] i_sfr_addr,
	input  wire       i_sfr_wr,
	input  wire       i_sfr_rd,
	input  wire [7:0] i_sfr_wdata,
	output wire [7:0] o_sfr_rdata,
	output wire       o_sfr_rvalid,
	input  wire       i_sys_on,
	input  wire       i_cmp_high,
	output wire [7:0] o_dac_code,
	output wire       o_ch_sel,
	output wire       o_afe_enable,
	output wire       o_conv_busy,
	output wire       o_cmp_strobe
);

	localparam [1:0] ST_IDLE   = 2'd0;
	localparam [1:0] ST_SETTLE = 2'd1;
	localparam [1:0] ST_DECIDE = 2'd2;
	localparam [1:0] ST_DONE   = 2'd3;

	// least settling time per decision, rounded up to whole cycles
	localparam integer SETTLE_CYC =
		(`SAS_SETTLE_NS * `SAS_CLK_MHZ + 999) / 1000;
	localparam integer SETTLE_END = SETTLE_CYC - 1;
	localparam integer AUTO_END   = P_AUTO_CYCLES - 1;
	// counter widths fit the documented clock and interval
	localparam [7:0]  SETTLE_LAST = SETTLE_END[7:0];
	localparam [20:0] AUTO_LAST   = AUTO_END[20:0];
	localparam [7:0]  CTRL_RESET  = `SAS_CONTROL_RESET;

	function sfr_hit;
		input [7:0] addr;
		input [7:0] target;
		begin
			sfr_hit = (addr == target);
		end
	endfunction

	reg  [1:0]  state_ff;
	reg  [1:0]  nxt_state;
	reg  [7:0]  settle_ff;
	reg  [7:0]  nxt_settle;
	reg         req_ff;
	reg         nxt_req;
	reg         ch_ff;
	reg         nxt_ch;
	reg         auto_ff;
	reg         nxt_auto;
	reg  [7:0]  result_ff;
	reg  [7:0]  nxt_result;
	reg         by_req_ff;
	reg         nxt_by_req;
	reg  [20:0] auto_cnt_ff;
	reg  [20:0] nxt_auto_cnt;
	reg         auto_pend_ff;
	reg         nxt_auto_pend;
	reg  [7:0]  rdata_ff;
	reg  [7:0]  nxt_rdata;
	reg         rvalid_ff;
	reg         busy_ff;
	reg         afe_en_ff;
	reg         start;
	reg         finish;
	wire        decide;
	wire        wr_ctrl;
	wire        rd_ctrl;
	wire        rd_result;
	wire [7:0]  sar_code;
	wire        sar_last;
	wire [7:0]  ctrl_view;
	wire        auto_run;
	wire        auto_tick;

	assign wr_ctrl   = i_sfr_wr & sfr_hit(i_sfr_addr, `SAS_ADDR_CONTROL);
	assign rd_ctrl   = i_sfr_rd & sfr_hit(i_sfr_addr, `SAS_ADDR_CONTROL);
	assign rd_result = i_sfr_rd & sfr_hit(i_sfr_addr, `SAS_ADDR_RESULT);
	assign decide    = (state_ff == ST_DECIDE);
	// interval expires on the last count; both timer updates read it
	assign auto_run  = auto_ff & i_sys_on;
	assign auto_tick = auto_run & (auto_cnt_ff == AUTO_LAST);

	// reserved bits are not stored and read as zero
	assign ctrl_view = {5'b00000, auto_ff, ch_ff, req_ff};

	sas_sar_core u_sar (
		.i_clk_sys  (i_clk_sys),
		.i_rst_n    (i_rst_n),
		.i_start    (start),
		.i_decide   (decide),
		.i_cmp_high (i_cmp_high),
		.o_code     (sar_code),
		.o_last     (sar_last)
	);

	// conversion state machine; dropping out of system-on aborts
	always @* begin
		nxt_state  = state_ff;
		nxt_settle = settle_ff;
		start      = 1'b0;
		finish     = 1'b0;
		case (state_ff)
			ST_IDLE: begin
				if (i_sys_on && (req_ff || auto_pend_ff)) begin
					start      = 1'b1;
					nxt_settle = 8'h00;
					nxt_state  = ST_SETTLE;
				end
			end
			ST_SETTLE: begin
				// a fixed settle per bit keeps a conversion to a few
				// hundred cycles, far inside the allowed time
				if (settle_ff == SETTLE_LAST) begin
					nxt_state = ST_DECIDE;
				end else begin
					nxt_settle = settle_ff + 8'h01;
				end
			end
			ST_DECIDE: begin
				nxt_settle = 8'h00;
				// eight decisions end the conversion
				nxt_state  = sar_last ? ST_DONE : ST_SETTLE;
			end
			ST_DONE: begin
				finish    = 1'b1;
				nxt_state = ST_IDLE;
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
		if (!i_sys_on) begin
			nxt_state = ST_IDLE;
			start     = 1'b0;
			finish    = 1'b0;
		end
	end

	// control register: software write wins over the hardware clear
	always @* begin
		nxt_req    = req_ff;
		nxt_ch     = ch_ff;
		nxt_auto   = auto_ff;
		nxt_by_req = by_req_ff;
		nxt_result = result_ff;
		if (start) begin
			nxt_by_req = req_ff;
		end
		if (finish) begin
			// copy the code, which spans full scale in lsb steps
			nxt_result = sar_code;
			if (by_req_ff) begin
				nxt_req = 1'b0;
			end
		end
		if (wr_ctrl) begin
			nxt_req  = i_sfr_wdata[`SAS_CTRL_REQ_BIT];
			// mux follows this bit; software keeps it still while busy
			nxt_ch   = i_sfr_wdata[`SAS_CTRL_CHSEL_BIT];
			nxt_auto = i_sfr_wdata[`SAS_CTRL_AUTO_BIT];
		end
	end

	// interval timer held at zero while disabled, so enabling restarts it
	always @* begin
		nxt_auto_cnt  = auto_cnt_ff;
		nxt_auto_pend = auto_pend_ff;
		if (!auto_run) begin
			nxt_auto_cnt  = 21'd0;
			nxt_auto_pend = 1'b0;
		end else begin
			if (auto_tick) begin
				nxt_auto_cnt = 21'd0;
			end else begin
				nxt_auto_cnt = auto_cnt_ff + 21'd1;
			end
			if (start) begin
				nxt_auto_pend = 1'b0;
			end
			// a tick during a running conversion waits for idle
			if (auto_tick) begin
				nxt_auto_pend = 1'b1;
			end
		end
	end

	// result register has no write path at all
	always @* begin
		nxt_rdata = `SAS_READ_UNMAPPED;
		if (rd_ctrl) begin
			nxt_rdata = ctrl_view;
		end else if (rd_result) begin
			nxt_rdata = result_ff;
		end
	end

	// conversion state; busy is registered from the next state so it
	// rises with the start edge and falls with the result copy
	always @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			state_ff  <= ST_IDLE;
			settle_ff <= 8'h00;
			by_req_ff <= 1'b0;
			busy_ff   <= 1'b0;
			afe_en_ff <= 1'b0;
		end else begin
			state_ff  <= nxt_state;
			settle_ff <= nxt_settle;
			by_req_ff <= nxt_by_req;
			busy_ff   <= (nxt_state != ST_IDLE);
			afe_en_ff <= i_sys_on;
		end
	end

	// software-visible control fields and the result
	always @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			req_ff    <= CTRL_RESET[`SAS_CTRL_REQ_BIT];
			ch_ff     <= CTRL_RESET[`SAS_CTRL_CHSEL_BIT];
			auto_ff   <= CTRL_RESET[`SAS_CTRL_AUTO_BIT];
			result_ff <= `SAS_RESULT_RESET;
		end else begin
			req_ff    <= nxt_req;
			ch_ff     <= nxt_ch;
			auto_ff   <= nxt_auto;
			result_ff <= nxt_result;
		end
	end

	// automatic-conversion interval timer
	always @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			auto_cnt_ff  <= 21'd0;
			auto_pend_ff <= 1'b0;
		end else begin
			auto_cnt_ff  <= nxt_auto_cnt;
			auto_pend_ff <= nxt_auto_pend;
		end
	end

	// read port: data and valid stand for exactly one cycle
	always @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			rdata_ff  <= `SAS_READ_UNMAPPED;
			rvalid_ff <= 1'b0;
		end else begin
			rdata_ff  <= nxt_rdata;
			rvalid_ff <= i_sfr_rd;
		end
	end

	assign o_sfr_rdata  = rdata_ff;
	assign o_sfr_rvalid = rvalid_ff;
	// trial code to the stepped source, one shared converter
	assign o_dac_code   = sar_code;
	assign o_ch_sel     = ch_ff;
	assign o_afe_enable = afe_en_ff;
	assign o_conv_busy  = busy_ff;
	assign o_cmp_strobe = decide;

endmodule

// ===== tb/sas_sequencer_checker.sv
/* port checker for the converter sequencer
   assumes it is bound onto sas_sequencer and shares its clock and reset */
`timescale 1ns/1ps
module sas_sequencer_checker (
	input wire       i_clk_sys,
	input wire       i_rst_n,
	input wire [7:0] i_sfr_addr,
	input wire       i_sfr_wr,
	input wire       i_sfr_rd,
	input wire [7:0] i_sfr_wdata,
	input wire [7:0] o_sfr_rdata,
	input wire       o_sfr_rvalid,
	input wire       i_sys_on,
	input wire       i_cmp_high,
	input wire [7:0] o_dac_code,
	input wire       o_ch_sel,
	input wire       o_afe_enable,
	input wire       o_conv_busy,
	input wire       o_cmp_strobe
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	a_msb_first: assert property (
		$rose(o_conv_busy) |-> o_dac_code == 8'h80)
		else $error("first trial code is not the top bit");
	// the comparator must settle before the first decision is taken
	a_settle_first: assert property (
		$rose(o_conv_busy) |-> !o_cmp_strobe [*8])
		else $error("decision taken without settling");
	a_strobe_once: assert property (
		o_cmp_strobe && i_sys_on |=> !o_cmp_strobe && o_conv_busy)
		else $error("decision strobe not a single busy cycle");
	a_conv_bound: assert property (
		$rose(o_conv_busy) |-> ##[1:420] !o_conv_busy)
		else $error("conversion overran its limit");
	a_rsvd_zero: assert property (
		i_sfr_rd && i_sfr_addr == 8'hC3 |=> o_sfr_rdata[7:3] == 5'h00)
		else $error("reserved control bits read nonzero");
	a_ch_follow: assert property (
		i_sfr_wr && i_sfr_addr == 8'hC3 |=> o_ch_sel == $past(i_sfr_wdata[1]))
		else $error("channel select does not follow write");
	a_off_abort: assert property (!i_sys_on |=> !o_conv_busy)
		else $error("busy while system is off");
	a_afe_on: assert property (i_sys_on |=> o_afe_enable)
		else $error("front end not enabled in system on");
	c_done: cover property ($fell(o_conv_busy));
	c_keep: cover property (o_cmp_strobe && i_cmp_high);
	c_abort: cover property (!i_sys_on && o_conv_busy);
endmodule
bind sas_sequencer sas_sequencer_checker i_sas_sequencer_checker (.*);

// ===== tb/sas_sequencer_tb.sv
/* self-checking bench for the converter sequencer
   assumes the sequencer and its bound checker are compiled alongside */
`timescale 1ns/1ps
module sas_sequencer_tb;
	reg        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
	reg        sys_on = 1'b1, cmp = 1'b0;
	reg  [7:0] addr = 8'h00, wdata = 8'h00, ain0 = 8'h00, ain1 = 8'h00;
	wire [7:0] rdata, dac;
	wire       rvalid, ch, afe, busy, strobe;
	integer    error_cnt = 0, checks_done = 0, cyc = 0, n, k;
	sas_sequencer #(.P_AUTO_CYCLES(600)) i_sas_sequencer (
		.i_clk_sys(clk), .i_rst_n(rst_n), .i_sfr_addr(addr),
		.i_sfr_wr(wr), .i_sfr_rd(rd), .i_sfr_wdata(wdata),
		.o_sfr_rdata(rdata), .o_sfr_rvalid(rvalid), .i_sys_on(sys_on),
		.i_cmp_high(cmp), .o_dac_code(dac), .o_ch_sel(ch),
		.o_afe_enable(afe), .o_conv_busy(busy), .o_cmp_strobe(strobe));
	initial forever #10 clk = ~clk;
	// comparator stand-in; registered so it never races the trial code
	always @(posedge clk) begin
		cmp <= ((ch ? ain1 : ain0) >= dac);
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			error_cnt = error_cnt + 1;
			report_and_stop;
		end
	end
	task chk(input [7:0] s, input [7:0] e);
		checks_done = checks_done + 1;
		if (s !== e) begin
			error_cnt = error_cnt + 1;
			$display("[ERR] %0t seen %h want %h", $time, s, e);
		end
	endtask
	task sfr_wr(input [7:0] a, input [7:0] v);
		@(posedge clk);
		{addr, wdata, wr} <= {a, v, 1'b1};
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// a missing read answer shows up as EE, never as a matching value
	task rd_chk(input [7:0] a, input [7:0] e);
		@(posedge clk);
		{addr, rd} <= {a, 1'b1};
		@(posedge clk);
		rd <= 1'b0;
		#1 chk((rvalid === 1'b1) ? rdata : 8'hEE, e);
	endtask
	task wait_idle;
		n = 0;
		do begin
			@(posedge clk);
			#1 n = n + 1;
		end while (busy !== 1'b0 && n < 500);
	endtask
	task t_regs;
		rd_chk(8'hC2, 8'h00);
		rd_chk(8'hC3, 8'h00);
		sfr_wr(8'hC2, 8'hFF);
		rd_chk(8'hC2, 8'h00);
		sfr_wr(8'hC3, 8'hF8);
		rd_chk(8'hC3, 8'h00);
		chk(busy, 1'b0);
		rd_chk(8'h10, 8'h00);
	endtask
	task t_conv(input c, input [7:0] t);
		ain0 = t;
		ain1 = t ^ 8'h3C;
		sfr_wr(8'hC3, {6'h00, c, 1'b1});
		wait_idle;
		chk(n == 410, 1'b1);
		chk(ch, c);
		chk(dac, c ? t ^ 8'h3C : t);
		rd_chk(8'hC2, c ? t ^ 8'h3C : t);
		rd_chk(8'hC3, {6'h00, c, 1'b0});
	endtask
	task t_abort;
		ain0 = 8'h3C;
		sfr_wr(8'hC3, 8'h01);
		repeat (100) @(posedge clk);
		sys_on <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk(busy, 1'b0);
		chk(afe, 1'b0);
		rd_chk(8'hC3, 8'h01);
		rd_chk(8'hC2, 8'hC3);
		@(posedge clk);
		sys_on <= 1'b1;
		repeat (3) @(posedge clk);
		wait_idle;
		rd_chk(8'hC2, 8'h3C);
	endtask
	// timer restarts at enable, so exactly two starts fit in 1300 cycles
	task t_auto;
		integer cnt;
		reg     prev;
		cnt = 0;
		prev = 1'b0;
		ain0 = 8'h96;
		sfr_wr(8'hC3, 8'h04);
		repeat (1300) begin
			@(posedge clk);
			#1 cnt = cnt + (busy && !prev);
			prev = busy;
		end
		chk(cnt == 2, 1'b1);
		rd_chk(8'hC3, 8'h04);
		rd_chk(8'hC2, 8'h96);
		sfr_wr(8'hC3, 8'h00);
		wait_idle;
	endtask
	task report_and_stop;
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_regs;
		for (k = 0; k < 4; k = k + 1)
			t_conv(k[0], {4{k[1:0]}});
		t_abort;
		t_auto;
		report_and_stop;
	end
endmodule
